// *** spr_pkg.sv ***
// package for the sleep and power reduction controller
// assumes one system clock and a plain register port
package spr_pkg;

  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam logic [1:0] ADDR_CORE_CTRL = 2'h0; // core_control_register
  localparam logic [1:0] ADDR_CLK_GATE = 2'h1;  // peripheral_clock_gate
  localparam logic [1:0] ADDR_STATUS = 2'h2;    // sleep status, read only
  localparam logic [1:0] ADDR_WAKE_EN = 2'h3;   // wake source enables

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int POS_SLEEP_SEL_LO = 3;
  localparam int POS_SLEEP_SEL_HI = 4;
  localparam int POS_SLEEP_ENABLE = 5;
  localparam logic [7:0] CORE_CTRL_WMASK = 8'h7B; // bits 7 and 2 read zero
  localparam logic [7:0] CLK_GATE_WMASK = 8'h0F;  // bits 7:4 read zero
  localparam int POS_GATE_CONVERTER = 0;
  localparam int POS_GATE_SERIAL = 1;
  localparam int POS_GATE_TIMER_ZERO = 2;
  localparam int POS_GATE_TIMER_ONE = 3;

  // ------------------------------------------------------------
  // reset values and timing
  // ------------------------------------------------------------
  localparam logic [7:0] CORE_CTRL_RESET = 8'h00;
  localparam logic [7:0] CLK_GATE_RESET = 8'h00;
  localparam logic [7:0] WAKE_EN_RESET = 8'h00;
  localparam int WAKE_HALT_CYCLES = 4;
  localparam logic [2:0] WAKE_HALT_LAST = 3'(WAKE_HALT_CYCLES - 1);

  // ------------------------------------------------------------
  // sleep mode codes
  // ------------------------------------------------------------
  localparam logic [1:0] MODE_IDLE = 2'h0;
  localparam logic [1:0] MODE_NOISE = 2'h1;
  localparam logic [1:0] MODE_POWER_DOWN = 2'h2;

  // controller states, gray along run-sleep-halt
  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_SLEEP = 2'b01,
    ST_HALT = 2'b11
  } spr_state_type;

  // wake sources
  typedef struct packed {
    logic conv_done;
    logic mem_ready;
    logic ext_level;
    logic ext_edge;
    logic pin_change;
    logic serial_start;
    logic watchdog_irq;
    logic other_io;
  } spr_wake_type;

  // clock and analog enables
  typedef struct packed {
    logic cpu;
    logic flash;
    logic io;
    logic conv;
    logic fast_periph;
    logic osc;
    logic timer_one;
    logic timer_zero;
    logic serial;
    logic conv_gate;
  } spr_clk_type;

  // whole controller state
  typedef struct packed {
    spr_state_type st;
    logic [1:0] mode;
    logic [2:0] halt_cnt;
    logic [7:0] core_ctrl;
    logic [7:0] clk_gate;
    logic [7:0] wake_en;
    logic [7:0] rdata;
    spr_clk_type clk;
    logic conv_start;
    logic cmp_off;
    logic ref_on;
    logic bod_on;
    logic conv_extended;
    logic conv_was_on;
    logic periph_access;
    logic irq_run;
  } spr_regs_type;

endpackage

// *** spr_ctrl.sv ***
// sleep mode and per peripheral clock gating controller
// assumes cpu drives sleep instruction pulse and register strobes synchronously
//
// Functional notes
// - sleep select 00 idle, 01 noise reduction, 10 power-down, 11 reserved
// - control register bit 2 always reads zero
// - idle stops only cpu and flash clocks
// - idle wakes on any enabled interrupt, pin or internal
// - enabled converter starts conversion on entering idle or noise reduction; code skips the start while gate bit 0 is set
// - noise reduction stops io, cpu and flash clocks; converter clock runs
// - noise reduction wakes only on its listed events
// - power-down stops oscillator and every generated clock
// - power-down wakes only on its listed events
// - external pin wakes deep modes only in level mode
// - oscillator on in idle and noise; fast clock and other io idle only
// - gate bit stops peripheral clock and blocks its register access
// - clearing gate bit restarts clock, state preserved
// - gate register bits 7:4 read zero
// - bit 3 gates timer one, bit 2 gates timer zero
// - bit 1 gates serial unit; software reinitialises it
// - bit 0 gates converter; comparator loses converter multiplexer
// - converter stays enabled in sleep; re-enable gives extended conversion
// - comparator off in power-down; reference kept if comparator uses it
// - enabled brown-out detector stays active in every sleep mode
// - sleep entered only with enable bit set and sleep instruction
// - interrupt wake halts four cycles then runs handler; reset restarts
`timescale 1ns/1ps

module spr_ctrl (
  // clock and reset
  input wire logic CLOCK,
  input wire logic RST,
  // register port
  input wire logic [1:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  // cpu side
  input wire logic SLEEP_INSN,
  input wire logic ANY_IRQ,
  input wire logic EXT_LEVEL_MODE,
  // peripheral state
  input wire logic CONV_ENABLED,
  input wire logic CMP_ENABLED,
  input wire logic CMP_USES_REF,
  input wire logic BOD_FUSE_ON,
  input wire spr_pkg::spr_wake_type WAKE_SRC,
  input wire logic [1:0] PERIPH_SEL,
  // clock and analog controls
  output spr_pkg::spr_clk_type CLK_EN,
  output logic SLEEPING,
  output logic CONV_START,
  output logic CMP_FORCE_OFF,
  output logic REF_KEEP_ON,
  output logic BOD_ACTIVE,
  output logic CONV_EXTENDED,
  output logic PERIPH_ACCESS_OK,
  output logic IRQ_RUN
);

  spr_pkg::spr_regs_type r_r;
  spr_pkg::spr_regs_type r_nxt;
  logic wake;
  logic [1:0] mode_sel;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------

  // wake qualification per mode
  function automatic logic wake_ok(input logic [1:0] m, input spr_pkg::spr_wake_type w,
                                   input logic [7:0] en, input logic irq, input logic lvl);
    spr_pkg::spr_wake_type q;
    logic ext;
    q = w & spr_pkg::spr_wake_type'(en);
    ext = q.ext_level & lvl;
    unique case (m)
      spr_pkg::MODE_IDLE: wake_ok = irq | (|q);
      spr_pkg::MODE_NOISE: wake_ok = q.conv_done | q.mem_ready | ext | q.pin_change
                                   | q.serial_start | q.watchdog_irq;
      spr_pkg::MODE_POWER_DOWN: wake_ok = q.serial_start | q.watchdog_irq | ext
                                        | q.pin_change;
      default: wake_ok = 1'b0;
    endcase
  endfunction

  // clock enables from state, mode and gate bits
  function automatic spr_pkg::spr_clk_type clocks(input logic slp, input logic [1:0] m,
                                                  input logic [7:0] g);
    spr_pkg::spr_clk_type c;
    logic idle;
    logic noise;
    idle = slp && m == spr_pkg::MODE_IDLE;
    noise = slp && m == spr_pkg::MODE_NOISE;
    c.cpu = !slp;
    c.flash = !slp;
    c.io = !slp || idle;
    c.conv = !slp || idle || noise;
    c.fast_periph = !slp || idle;
    c.osc = !slp || idle || noise;
    c.timer_one = c.io && !g[spr_pkg::POS_GATE_TIMER_ONE];
    c.timer_zero = c.io && !g[spr_pkg::POS_GATE_TIMER_ZERO];
    c.serial = c.io && !g[spr_pkg::POS_GATE_SERIAL];
    c.conv_gate = c.conv && !g[spr_pkg::POS_GATE_CONVERTER];
    clocks = c;
  endfunction

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  assign mode_sel = r_r.core_ctrl[spr_pkg::POS_SLEEP_SEL_HI:spr_pkg::POS_SLEEP_SEL_LO];
  assign wake = wake_ok(r_r.mode, WAKE_SRC, r_r.wake_en, ANY_IRQ, EXT_LEVEL_MODE);

  always_comb begin
    r_nxt = r_r;
    r_nxt.conv_start = 1'b0;
    r_nxt.irq_run = 1'b0;
    r_nxt.rdata = 8'h00;
    unique case (r_r.st)
      spr_pkg::ST_RUN: begin
        if (SLEEP_INSN && r_r.core_ctrl[spr_pkg::POS_SLEEP_ENABLE]
            && mode_sel != 2'h3) begin
          r_nxt.st = spr_pkg::ST_SLEEP;
          r_nxt.mode = mode_sel;
          r_nxt.conv_start = CONV_ENABLED && mode_sel != spr_pkg::MODE_POWER_DOWN
                             && !r_r.clk_gate[spr_pkg::POS_GATE_CONVERTER];
        end
      end
      spr_pkg::ST_SLEEP: begin
        if (wake) begin
          r_nxt.st = spr_pkg::ST_HALT;
          r_nxt.halt_cnt = 3'h0;
        end
      end
      spr_pkg::ST_HALT: begin
        r_nxt.halt_cnt = r_r.halt_cnt + 3'h1;
        if (r_r.halt_cnt == spr_pkg::WAKE_HALT_LAST) begin
          r_nxt.st = spr_pkg::ST_RUN;
          r_nxt.irq_run = 1'b1;
        end
      end
      default: r_nxt.st = spr_pkg::ST_RUN;
    endcase
    // register writes only while the cpu runs
    if (WR && r_r.st == spr_pkg::ST_RUN) begin
      unique case (ADDR)
        spr_pkg::ADDR_CORE_CTRL: r_nxt.core_ctrl = WDATA & spr_pkg::CORE_CTRL_WMASK;
        spr_pkg::ADDR_CLK_GATE: r_nxt.clk_gate = WDATA & spr_pkg::CLK_GATE_WMASK;
        spr_pkg::ADDR_WAKE_EN: r_nxt.wake_en = WDATA;
        default: ;
      endcase
    end
    // read data next cycle
    if (RD) begin
      unique case (ADDR)
        spr_pkg::ADDR_CORE_CTRL: r_nxt.rdata = r_r.core_ctrl;
        spr_pkg::ADDR_CLK_GATE: r_nxt.rdata = r_r.clk_gate;
        spr_pkg::ADDR_STATUS: r_nxt.rdata = {4'h0, r_r.st, r_r.mode};
        default: r_nxt.rdata = r_r.wake_en;
      endcase
    end
    r_nxt.clk = clocks(r_nxt.st != spr_pkg::ST_RUN, r_nxt.mode, r_nxt.clk_gate);
    // access to a peripheral is blocked while its gate bit is set
    r_nxt.periph_access = !r_nxt.clk_gate[PERIPH_SEL] && r_nxt.clk.io;
    r_nxt.cmp_off = r_nxt.st != spr_pkg::ST_RUN
                    && r_nxt.mode == spr_pkg::MODE_POWER_DOWN;
    r_nxt.ref_on = CMP_ENABLED && CMP_USES_REF;
    r_nxt.bod_on = BOD_FUSE_ON;
    // extended conversion after converter off then on
    r_nxt.conv_was_on = CONV_ENABLED;
    if (CONV_ENABLED && !r_r.conv_was_on) begin
      r_nxt.conv_extended = 1'b1;
    end else if (r_r.conv_start) begin
      r_nxt.conv_extended = 1'b0;
    end
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      r_r <= '0; // gate and control clear, all clocks restart below
      r_r.core_ctrl <= spr_pkg::CORE_CTRL_RESET;
      r_r.clk_gate <= spr_pkg::CLK_GATE_RESET;
      r_r.wake_en <= spr_pkg::WAKE_EN_RESET;
      r_r.clk <= '1;
      r_r.periph_access <= 1'b1;
      r_r.conv_extended <= 1'b1;
    end else begin
      r_r <= r_nxt;
    end
  end

  // outputs straight from flops; SLEEPING decoded from the state flops
  assign RDATA = r_r.rdata;
  assign CLK_EN = r_r.clk;
  assign SLEEPING = r_r.st != spr_pkg::ST_RUN;
  assign CONV_START = r_r.conv_start;
  assign CMP_FORCE_OFF = r_r.cmp_off;
  assign REF_KEEP_ON = r_r.ref_on;
  assign BOD_ACTIVE = r_r.bod_on;
  assign CONV_EXTENDED = r_r.conv_extended;
  assign PERIPH_ACCESS_OK = r_r.periph_access;
  assign IRQ_RUN = r_r.irq_run;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  property p_mode_field;
    @(posedge CLOCK) disable iff (RST) SLEEPING |-> r_r.mode != 2'h3;
  endproperty
  a_mode_field: assert property (p_mode_field) else $error("reserved mode entered");

  property p_reserved_bit;
    @(posedge CLOCK) disable iff (RST) RD && ADDR == spr_pkg::ADDR_CORE_CTRL |=> !RDATA[2];
  endproperty
  a_reserved_bit: assert property (p_reserved_bit) else $error("bit 2 not zero");

  property p_idle_clocks;
    @(posedge CLOCK) disable iff (RST)
      SLEEPING && r_r.mode == spr_pkg::MODE_IDLE |-> !CLK_EN.cpu && CLK_EN.io && CLK_EN.osc;
  endproperty
  a_idle_clocks: assert property (p_idle_clocks) else $error("idle clocks wrong");

  property p_noise_clocks;
    @(posedge CLOCK) disable iff (RST)
      SLEEPING && r_r.mode == spr_pkg::MODE_NOISE |-> !CLK_EN.io && CLK_EN.conv;
  endproperty
  a_noise_clocks: assert property (p_noise_clocks) else $error("noise clocks wrong");

  property p_pd_clocks;
    @(posedge CLOCK) disable iff (RST)
      SLEEPING && r_r.mode == spr_pkg::MODE_POWER_DOWN |-> !CLK_EN.osc && !CLK_EN.conv;
  endproperty
  a_pd_clocks: assert property (p_pd_clocks) else $error("power-down clock on");

  property p_gate_top;
    @(posedge CLOCK) disable iff (RST) RD && ADDR == spr_pkg::ADDR_CLK_GATE |=> RDATA[7:4] == 4'h0;
  endproperty
  a_gate_top: assert property (p_gate_top) else $error("gate upper bits set");

  property p_timer_gate;
    @(posedge CLOCK) disable iff (RST)
      r_r.clk_gate[spr_pkg::POS_GATE_TIMER_ONE] |-> !CLK_EN.timer_one;
  endproperty
  a_timer_gate: assert property (p_timer_gate) else $error("timer one clock not gated");

  property p_wake_halt;
    @(posedge CLOCK) disable iff (RST)
      r_r.st == spr_pkg::ST_SLEEP && wake |=> SLEEPING [*4] ##1 IRQ_RUN;
  endproperty
  a_wake_halt: assert property (p_wake_halt) else $error("wake halt not four cycles");

  property p_no_enable;
    @(posedge CLOCK) disable iff (RST)
      !SLEEPING && SLEEP_INSN && !r_r.core_ctrl[spr_pkg::POS_SLEEP_ENABLE] |=> !SLEEPING;
  endproperty
  a_no_enable: assert property (p_no_enable) else $error("slept without enable");

  property p_conv_start;
    @(posedge CLOCK) disable iff (RST) CONV_START |-> SLEEPING && r_r.mode != spr_pkg::MODE_POWER_DOWN;
  endproperty
  a_conv_start: assert property (p_conv_start) else $error("bad conversion start");

  // no wake source of the noise list keeps the core asleep
  property p_noise_wake;
    @(posedge CLOCK) disable iff (RST)
      r_r.st == spr_pkg::ST_SLEEP && r_r.mode == spr_pkg::MODE_NOISE
      && !(WAKE_SRC.conv_done || WAKE_SRC.mem_ready || WAKE_SRC.pin_change
      || WAKE_SRC.serial_start || WAKE_SRC.watchdog_irq
      || (WAKE_SRC.ext_level && EXT_LEVEL_MODE)) |=> SLEEPING;
  endproperty
  a_noise_wake: assert property (p_noise_wake) else $error("noise woke on wrong source");

  // no wake source of the power-down list keeps the core asleep
  property p_pd_wake;
    @(posedge CLOCK) disable iff (RST)
      r_r.st == spr_pkg::ST_SLEEP && r_r.mode == spr_pkg::MODE_POWER_DOWN
      && !(WAKE_SRC.pin_change || WAKE_SRC.serial_start || WAKE_SRC.watchdog_irq
      || (WAKE_SRC.ext_level && EXT_LEVEL_MODE)) |=> SLEEPING;
  endproperty
  a_pd_wake: assert property (p_pd_wake) else $error("power-down woke on wrong source");

  property p_fast_clock;
    @(posedge CLOCK) disable iff (RST)
      SLEEPING && r_r.mode != spr_pkg::MODE_IDLE |-> !CLK_EN.fast_periph;
  endproperty
  a_fast_clock: assert property (p_fast_clock) else $error("fast clock outside idle");

  property p_gate_restore;
    @(posedge CLOCK) disable iff (RST)
      !SLEEPING && r_r.clk_gate[3:0] == 4'h0 |-> CLK_EN[3:0] == 4'hF;
  endproperty
  a_gate_restore: assert property (p_gate_restore) else $error("clock not restored");

  property p_cmp_off;
    @(posedge CLOCK) disable iff (RST)
      SLEEPING && r_r.mode == spr_pkg::MODE_POWER_DOWN |-> CMP_FORCE_OFF;
  endproperty
  a_cmp_off: assert property (p_cmp_off) else $error("comparator on in power-down");

  property p_bod_kept;
    @(posedge CLOCK) disable iff (RST) BOD_FUSE_ON |=> BOD_ACTIVE;
  endproperty
  a_bod_kept: assert property (p_bod_kept) else $error("brown-out detector dropped");

  c_idle: cover property (@(posedge CLOCK) disable iff (RST)
    SLEEPING && r_r.mode == spr_pkg::MODE_IDLE ##[1:8] IRQ_RUN);
  c_noise: cover property (@(posedge CLOCK) disable iff (RST)
    SLEEPING && r_r.mode == spr_pkg::MODE_NOISE);
  c_pd: cover property (@(posedge CLOCK) disable iff (RST)
    SLEEPING && r_r.mode == spr_pkg::MODE_POWER_DOWN);
  c_gate: cover property (@(posedge CLOCK) disable iff (RST) !CLK_EN.serial && !SLEEPING);

endmodule

// *** tb_top.sv ***
// self-checking bench for the sleep and power reduction controller
// assumes spr_pkg compiled first; the bench drives every input port of spr_ctrl itself
`timescale 1ns/1ps

module tb_top;
  // ------------------------------------------------------------
  // signals and instance
  // ------------------------------------------------------------
  logic clock = 0;
  logic rst = 1;
  logic [1:0] addr = 0;
  logic [7:0] wdata = 0;
  logic wr = 0;
  logic rd = 0;
  logic sleep_insn = 0;
  logic any_irq = 0;
  logic ext_level_mode = 0;
  logic conv_enabled = 1;
  logic cmp_enabled = 1;
  logic cmp_uses_ref = 1;
  logic bod_fuse_on = 1;
  spr_pkg::spr_wake_type wake_src = '0;
  logic [1:0] periph_sel = 0;
  logic [7:0] rdata;
  spr_pkg::spr_clk_type clk_en;
  logic sleeping, conv_start, cmp_force_off, ref_keep_on, bod_active;
  logic conv_extended, periph_access_ok, irq_run;
  int n_fail = 0;
  int n_checks = 0;

  spr_ctrl i_spr_ctrl (.CLOCK(clock), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr),
    .RD(rd), .RDATA(rdata), .SLEEP_INSN(sleep_insn), .ANY_IRQ(any_irq),
    .EXT_LEVEL_MODE(ext_level_mode), .CONV_ENABLED(conv_enabled), .CMP_ENABLED(cmp_enabled),
    .CMP_USES_REF(cmp_uses_ref), .BOD_FUSE_ON(bod_fuse_on), .WAKE_SRC(wake_src),
    .PERIPH_SEL(periph_sel), .CLK_EN(clk_en), .SLEEPING(sleeping), .CONV_START(conv_start),
    .CMP_FORCE_OFF(cmp_force_off), .REF_KEEP_ON(ref_keep_on), .BOD_ACTIVE(bod_active),
    .CONV_EXTENDED(conv_extended), .PERIPH_ACCESS_OK(periph_access_ok), .IRQ_RUN(irq_run));

  // 250 MHz system clock
  initial begin
    forever #2 clock = ~clock;
  end

  // ------------------------------------------------------------
  // compare, bus and closing tasks
  // ------------------------------------------------------------
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk_bit(string name, logic exp, logic got);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %b seen %b", name, exp, got);
    end
  endtask

  task automatic chk_vec(string name, logic [9:0] exp, logic [9:0] got);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  // one-cycle write strobe
  task automatic reg_wr(logic [1:0] a, logic [7:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask

  // one-cycle read strobe, data judged in the following cycle
  task automatic reg_rd(logic [1:0] a, logic [7:0] exp, string name);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    @(negedge clock);
    chk_vec(name, {2'h0, exp}, {2'h0, rdata});
  endtask

  task automatic pulse_sleep();
    @(posedge clock);
    sleep_insn <= 1'b1;
    @(posedge clock);
    sleep_insn <= 1'b0;
    @(negedge clock);
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic test_regs();
    chk_vec("clk_en after reset", 10'h3FF, clk_en);
    reg_rd(spr_pkg::ADDR_CLK_GATE, 8'h00, "gate reset");
    reg_wr(spr_pkg::ADDR_CLK_GATE, 8'hFF);
    reg_rd(spr_pkg::ADDR_CLK_GATE, 8'h0F, "gate upper bits");
    reg_wr(spr_pkg::ADDR_CORE_CTRL, 8'hFF);
    reg_rd(spr_pkg::ADDR_CORE_CTRL, 8'h7B, "core bit 2");
    reg_wr(spr_pkg::ADDR_STATUS, 8'hFF);
    reg_rd(spr_pkg::ADDR_STATUS, 8'h00, "status read only");
    reg_wr(spr_pkg::ADDR_CLK_GATE, 8'h00);
    $display("test registers done");
  endtask

  // each gate bit alone stops its own clock and blocks access
  task automatic test_gates();
    logic [3:0] g;
    for (int k = 0; k < 4; k++) begin
      g = 4'h1 << k;
      periph_sel <= 2'(k);
      reg_wr(spr_pkg::ADDR_CLK_GATE, {4'h0, g});
      repeat (2) @(posedge clock);
      @(negedge clock);
      chk_vec("gated clocks", {6'h3F, ~g}, clk_en);
      chk_bit("access while gated", 1'b0, periph_access_ok);
      reg_wr(spr_pkg::ADDR_CLK_GATE, 8'h00);
      repeat (2) @(posedge clock);
      @(negedge clock);
      chk_vec("clocks restored", 10'h3FF, clk_en);
      chk_bit("access restored", 1'b1, periph_access_ok);
    end
    $display("test gates done");
  endtask

  // reserved select and missing enable bit leave the core running
  task automatic test_refused();
    reg_wr(spr_pkg::ADDR_CORE_CTRL, 8'h38);
    pulse_sleep();
    chk_bit("reserved select", 1'b0, sleeping);
    reg_wr(spr_pkg::ADDR_CORE_CTRL, 8'h10);
    pulse_sleep();
    chk_bit("no enable bit", 1'b0, sleeping);
    $display("test refused sleep done");
  endtask

  // enter a mode, offer wrong wake sources, then a right one
  task automatic test_mode(logic [1:0] m, logic [7:0] bad, logic [7:0] good, logic irq);
    logic [5:0] exp_top;
    int i;
    exp_top = (m == 2'h0) ? 6'h0F : (m == 2'h1) ? 6'h05 : 6'h00;
    reg_wr(spr_pkg::ADDR_WAKE_EN, 8'hFF);
    reg_wr(spr_pkg::ADDR_CORE_CTRL, {2'h0, 1'b1, m, 3'h0});
    pulse_sleep();
    chk_bit("sleeping", 1'b1, sleeping);
    chk_vec("mode clocks", {4'h0, exp_top}, {4'h0, clk_en[9:4]});
    chk_bit("conv start", m != 2'h2, conv_start);
    chk_bit("cmp off", m == 2'h2, cmp_force_off);
    chk_bit("ref kept", 1'b1, ref_keep_on);
    chk_bit("bod active", 1'b1, bod_active);
    @(posedge clock);
    wake_src <= bad;
    any_irq <= (m != 2'h0);
    ext_level_mode <= 1'b0;
    repeat (8) @(posedge clock);
    @(negedge clock);
    chk_bit("ignored wake", 1'b1, sleeping);
    chk_bit("conv stays on", 1'b0, conv_extended);
    @(posedge clock);
    wake_src <= good;
    any_irq <= irq;
    ext_level_mode <= 1'b1;
    for (i = 1; i <= 20; i++) begin
      @(negedge clock);
      if (irq_run === 1'b1) break;
    end
    if (i > 20) begin
      n_fail++;
      $display("CHECK FAILED wake timeout expected 6 seen none");
      stop_test();
    end
    // first poll before any edge, one edge samples the source and enters the halt, then the halt count
    chk_vec("wake latency", 10'(spr_pkg::WAKE_HALT_CYCLES + 2), 10'(i));
    chk_bit("awake", 1'b0, sleeping);
    chk_vec("clocks on", 10'h3FF, clk_en);
    @(posedge clock);
    wake_src <= '0;
    any_irq <= 1'b0;
    ext_level_mode <= 1'b0;
    $display("test sleep mode %0d done", m);
  endtask

  // re-enabled converter asks for an extended conversion
  task automatic test_conv_cycle();
    @(posedge clock);
    conv_enabled <= 1'b0;
    @(posedge clock);
    conv_enabled <= 1'b1;
    repeat (2) @(posedge clock);
    @(negedge clock);
    chk_bit("extended after re-enable", 1'b1, conv_extended);
    $display("test converter re-enable done");
  endtask

  // reset while asleep returns to run with every clock on
  task automatic test_reset_sleep();
    reg_wr(spr_pkg::ADDR_CLK_GATE, 8'h03);
    reg_wr(spr_pkg::ADDR_CORE_CTRL, {2'h0, 1'b1, spr_pkg::MODE_POWER_DOWN, 3'h0});
    pulse_sleep();
    chk_bit("asleep before reset", 1'b1, sleeping);
    @(posedge clock);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    @(negedge clock);
    chk_bit("awake after reset", 1'b0, sleeping);
    chk_bit("no handler after reset", 1'b0, irq_run);
    chk_vec("clocks after reset", 10'h3FF, clk_en);
    reg_rd(spr_pkg::ADDR_CLK_GATE, 8'h00, "gate after reset");
    reg_rd(spr_pkg::ADDR_CORE_CTRL, 8'h00, "core after reset");
    @(posedge clock);
    cmp_uses_ref <= 1'b0;
    bod_fuse_on <= 1'b0;
    repeat (2) @(posedge clock);
    @(negedge clock);
    chk_bit("ref released", 1'b0, ref_keep_on);
    chk_bit("bod off by setting", 1'b0, bod_active);
    $display("test reset in sleep done");
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    @(negedge clock);
    test_regs();
    test_gates();
    test_refused();
    test_mode(2'h0, 8'h00, 8'h00, 1'b1);
    test_mode(2'h1, 8'h31, 8'h80, 1'b0);
    test_mode(2'h2, 8'hF1, 8'h20, 1'b0);
    test_mode(2'h2, 8'hD1, 8'h04, 1'b0);
    test_conv_cycle();
    test_reset_sleep();
    stop_test();
  end
endmodule
